// ===== rtl/pwrflt_supervisor.sv
// fault supervisor: latches, bridge hi-z control and status pins
`timescale 1ns/100ps
`include "pwrflt_cfg.svh"
module pwrflt_supervisor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic resetPin_n,
	input wire logic [1:0] modeSel,
	input wire logic gateDriveSupplyOk,
	input wire logic logicSupplyOk,
	input wire logic overcurrentTrip,
	input wire logic thermalWarningDet,
	input wire logic thermalShutdownErrorDet,
	output logic [3:0] bridgeEnable,
	output logic [3:0] pulldownEnable,
	output logic shutdownAlertOut,
	output logic shutdownAlertOe,
	output logic thermalWarning
);
	pwrflt_pkg::pwrflt_flags_t rawFlags;
	pwrflt_pkg::pwrflt_flags_t syncFlags;
	logic rstHeld;
	logic uvFault;
	logic rstPrev_q, rstPrev_d;
	logic ocLatch_q, ocLatch_d;
	logic teLatch_q, teLatch_d;
	logic alertLow_q, alertLow_d;
	logic warn_q, warn_d;
	logic [3:0] bridgeEn_q, bridgeEn_d;
	logic [3:0] pullDn_q, pullDn_d;
	pwrflt_pkg::pwrflt_state_e state_q, state_d;

	// all-bridge replication of one enable bit
	function automatic logic [3:0] allBridges(input logic en);
		allBridges = {`PWRFLT_BRIDGES{en}};
	endfunction

	// ===========================================
	// input capture
	always_comb begin
		rawFlags = `PWRFLT_FLAGS_RESET;
		rawFlags[`PWRFLT_IDX_GATE] = gateDriveSupplyOk;
		rawFlags[`PWRFLT_IDX_LOGIC] = logicSupplyOk;
		rawFlags[`PWRFLT_IDX_OC] = overcurrentTrip;
		rawFlags[`PWRFLT_IDX_TW] = thermalWarningDet;
		rawFlags[`PWRFLT_IDX_TE] = thermalShutdownErrorDet;
		rawFlags[`PWRFLT_IDX_RST] = resetPin_n;
	end

	pwrflt_sync uSync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.asyncIn(rawFlags),
		.syncOut(syncFlags)
	);

	// synchronised reset pin low and undervoltage condition
	assign rstHeld = ~syncFlags[`PWRFLT_IDX_RST];
	assign uvFault = ~(syncFlags[`PWRFLT_IDX_GATE] & syncFlags[`PWRFLT_IDX_LOGIC]);

	// ===========================================
	// fault latches; a trip in the same cycle as the clear wins
	// release edge is seen on the synchronised pin, so a reset pulse under one clock may be lost
	always_comb begin
		rstPrev_d = rstHeld;
		ocLatch_d = ocLatch_q;
		teLatch_d = teLatch_q;
		// overcurrent clears only on the release edge of reset
		if (rstPrev_q && !rstHeld) begin
			ocLatch_d = 1'b0;
		end
		// thermal error clears while reset is held
		if (rstHeld) begin
			teLatch_d = 1'b0;
		end
		if (syncFlags[`PWRFLT_IDX_OC]) begin
			ocLatch_d = 1'b1;
		end
		if (syncFlags[`PWRFLT_IDX_TE]) begin
			teLatch_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rstPrev_q <= 1'b1;
			ocLatch_q <= 1'b0;
			teLatch_q <= 1'b0;
		end else if (clkEn) begin
			rstPrev_q <= rstPrev_d;
			ocLatch_q <= ocLatch_d;
			teLatch_q <= teLatch_d;
		end
	end

	// ===========================================
	// operating state: mute under reset, shut on any fault
	// mute outranks shut so a held reset also lets go of the alert line
	always_comb begin
		case (state_q)
			pwrflt_pkg::PWRFLT_RUN, pwrflt_pkg::PWRFLT_MUTE, pwrflt_pkg::PWRFLT_SHUT: begin
				if (rstHeld) begin
					state_d = pwrflt_pkg::PWRFLT_MUTE;
				end else if (uvFault || ocLatch_d || teLatch_d) begin
					state_d = pwrflt_pkg::PWRFLT_SHUT;
				end else begin
					state_d = pwrflt_pkg::PWRFLT_RUN;
				end
			end
			default: begin
				state_d = pwrflt_pkg::PWRFLT_MUTE;
			end
		endcase
	end

	// ===========================================
	// registered outputs; bridges and alert derived from the next state, pulldowns and warning from the synchronised inputs
	// decoding state_d instead of state_q saves one cycle of reaction time
	always_comb begin
		bridgeEn_d = allBridges(state_d == pwrflt_pkg::PWRFLT_RUN);
		// single-ended mode skips pulldowns, caps charged by pwm instead
		pullDn_d = allBridges(rstHeld && (modeSel != `PWRFLT_MODE_SE));
		alertLow_d = (state_d == pwrflt_pkg::PWRFLT_SHUT);
		warn_d = syncFlags[`PWRFLT_IDX_TW];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= pwrflt_pkg::PWRFLT_MUTE;
			bridgeEn_q <= 4'h0;
			pullDn_q <= 4'h0;
			alertLow_q <= 1'b0;
			warn_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			bridgeEn_q <= bridgeEn_d;
			pullDn_q <= pullDn_d;
			alertLow_q <= alertLow_d;
			warn_q <= warn_d;
		end
	end

	// open-drain alert only ever drives low; warning is push-pull
	assign shutdownAlertOut = 1'b0;
	assign shutdownAlertOe = alertLow_q;
	assign thermalWarning = warn_q;
	assign bridgeEnable = bridgeEn_q;
	assign pulldownEnable = pullDn_q;

	// ===========================================
	// assertions
	uv_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && uvFault |=> bridgeEnable == 4'h0)
		else $error("bridges enabled under undervoltage");
	rst_pulldown_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && rstHeld && modeSel != `PWRFLT_MODE_SE |=> pulldownEnable == 4'hf)
		else $error("pulldowns missing in reset");
	od_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		shutdownAlertOe |-> shutdownAlertOut == 1'b0)
		else $error("alert driven high");
	warn_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn |=> thermalWarning == $past(syncFlags[`PWRFLT_IDX_TW]))
		else $error("warning does not follow detector");
	alert_encode_a: assert property (@(posedge clk) disable iff (sys_rst)
		shutdownAlertOe |-> bridgeEnable == 4'h0)
		else $error("alert without shutdown");
	rst_alert_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && rstHeld |=> !shutdownAlertOe)
		else $error("alert low under reset");
	fault_shut_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !rstHeld && syncFlags[`PWRFLT_IDX_OC] |=> shutdownAlertOe && bridgeEnable == 4'h0)
		else $error("overcurrent not shut");
	auto_recover_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !rstHeld && !uvFault && !ocLatch_d && !teLatch_d |=> bridgeEnable == 4'hf)
		else $error("no automatic recovery");
	te_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && teLatch_q && !rstHeld |=> teLatch_q)
		else $error("thermal latch lost");
	oc_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && ocLatch_q && !(rstPrev_q && !rstHeld) |=> ocLatch_q)
		else $error("overcurrent latch lost");
	rst_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && rstHeld |=> bridgeEnable == 4'h0)
		else $error("bridges on in reset");
	sync_lat_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && syncFlags[`PWRFLT_IDX_TE] |=> teLatch_q)
		else $error("thermal error not latched");

	// ===========================================
	// assertions: latch clearing, freeze and status coding
	bridges_same_a: assert property (@(posedge clk) disable iff (sys_rst)
		bridgeEnable == 4'h0 || bridgeEnable == 4'hf)
		else $error("bridges split");
	pd_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !rstHeld |=> pulldownEnable == 4'h0)
		else $error("pulldowns on outside reset");
	se_nopd_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && modeSel == `PWRFLT_MODE_SE |=> pulldownEnable == 4'h0)
		else $error("pulldowns on in single-ended mode");
	oc_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && rstPrev_q && !rstHeld && !syncFlags[`PWRFLT_IDX_OC] |=> !ocLatch_q)
		else $error("overcurrent latch not cleared");
	te_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && rstHeld && !syncFlags[`PWRFLT_IDX_TE] |=> !teLatch_q)
		else $error("thermal latch not cleared");
	uv_alert_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !rstHeld && uvFault |=> shutdownAlertOe)
		else $error("undervoltage not signalled");
	te_shut_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !rstHeld && syncFlags[`PWRFLT_IDX_TE] |=> shutdownAlertOe && bridgeEnable == 4'h0)
		else $error("thermal error not shut");
	run_status_a: assert property (@(posedge clk) disable iff (sys_rst)
		bridgeEnable == 4'hf |-> !shutdownAlertOe && pulldownEnable == 4'h0)
		else $error("running with alert or pulldowns");
	freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!clkEn |=> $stable(bridgeEnable) && $stable(shutdownAlertOe) && $stable(thermalWarning))
		else $error("state moved while frozen");
	run_c: cover property (@(posedge clk) state_q == pwrflt_pkg::PWRFLT_RUN);
	oc_recover_c: cover property (@(posedge clk) ocLatch_q ##1 !ocLatch_q);
	uv_shut_c: cover property (@(posedge clk) uvFault && shutdownAlertOe);
	warn_c: cover property (@(posedge clk) thermalWarning && !shutdownAlertOe);
	te_latch_c: cover property (@(posedge clk) teLatch_q && !syncFlags[`PWRFLT_IDX_TE]);
endmodule

// ===== inc/pwrflt_cfg.svh
// constants for the power stage fault supervisor
// Functional notes
// - hi-z until both supplies above undervoltage
// - pulldowns in reset except single-ended mode
// - open-drain low alert, push-pull high warning
// - warning high above 125 C detector
// - alert and warning encode status
// - reset low forces alert inactive high
// - shutdown fault gives hi-z and alert
// - other faults recover automatically when cleared
// - thermal shutdown latched until reset
// - overcurrent cleared on reset rising edge
// - overcurrent trips all four half-bridges
// - reset low forces all bridges hi-z
`ifndef PWRFLT_CFG_SVH
`define PWRFLT_CFG_SVH
`define PWRFLT_SYNC_STAGES 2
`define PWRFLT_BRIDGES 4
`define PWRFLT_MODE_SE 2'h2
`define PWRFLT_FLAGS 6
`define PWRFLT_IDX_GATE 0
`define PWRFLT_IDX_LOGIC 1
`define PWRFLT_IDX_OC 2
`define PWRFLT_IDX_TW 3
`define PWRFLT_IDX_TE 4
`define PWRFLT_IDX_RST 5
`define PWRFLT_FLAGS_RESET 6'h00
`endif

// ===== inc/pwrflt_pkg.sv
// types for the power stage fault supervisor
package pwrflt_pkg;
	typedef logic [5:0] pwrflt_flags_t;
	typedef enum logic [1:0] {
		PWRFLT_RUN,
		PWRFLT_MUTE,
		PWRFLT_SHUT
	} pwrflt_state_e;
endpackage

// ===== rtl/pwrflt_sync.sv
// two flip-flop synchroniser bank for detector flags and reset
`timescale 1ns/100ps
`include "pwrflt_cfg.svh"
module pwrflt_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire pwrflt_pkg::pwrflt_flags_t asyncIn,
	output pwrflt_pkg::pwrflt_flags_t syncOut
);
	pwrflt_pkg::pwrflt_flags_t meta_q;
	pwrflt_pkg::pwrflt_flags_t meta_d;
	pwrflt_pkg::pwrflt_flags_t sync_q;
	pwrflt_pkg::pwrflt_flags_t sync_d;

	// ===========================================
	// synchroniser chain; first stage feeds only the second
	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (clkEn) begin
			meta_d = asyncIn;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= `PWRFLT_FLAGS_RESET;
			sync_q <= `PWRFLT_FLAGS_RESET;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign syncOut = sync_q;
endmodule

// ===== bench/pwrflt_host.sv
// controller-side model of the reset pin and the alert line
`timescale 1ns/100ps
module pwrflt_host (
	input wire logic clk,
	input wire logic alertOe,
	input wire logic alertOut,
	output logic resetPin_n,
	output logic alertPin
);
	// ==========================================
	// pins
	// pull-up wins whenever the device lets go of the line
	assign alertPin = alertOe ? alertOut : 1'b1;
	// start in reset so bootstrap charging can begin at once
	initial resetPin_n = 1'b0;
	// level change just after an edge, never on it
	task automatic setReset(input logic v);
		@(posedge clk);
		#2 resetPin_n = v;
	endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the power stage fault supervisor
`timescale 1ns/100ps
`include "pwrflt_cfg.svh"
module tb_top;
	// ==========================================
	// signals
	logic clk, sysRst, clkEn, gateOk, logicOk, oc, tw, te;
	logic resetPin_n, alertOe, alertOut, alertPin, thermalWarning;
	logic [1:0] modeSel;
	logic [3:0] bridgeEnable, pulldownEnable;
	int failCount = 0;
	int checkCount = 0;
	pwrflt_host host (.clk(clk), .alertOe(alertOe), .alertOut(alertOut), .resetPin_n(resetPin_n),
		.alertPin(alertPin));
	pwrflt_supervisor u_dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .resetPin_n(resetPin_n),
		.modeSel(modeSel), .gateDriveSupplyOk(gateOk), .logicSupplyOk(logicOk), .overcurrentTrip(oc),
		.thermalWarningDet(tw), .thermalShutdownErrorDet(te), .bridgeEnable(bridgeEnable),
		.pulldownEnable(pulldownEnable), .shutdownAlertOut(alertOut), .shutdownAlertOe(alertOe),
		.thermalWarning(thermalWarning));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ==========================================
	// helpers
	// status word: bridges, pulldowns, alert pin, warning
	function automatic logic [9:0] st();
		return {bridgeEnable, pulldownEnable, alertPin, thermalWarning};
	endfunction
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// detectors: gate, logic, overcurrent, warning, error
	task automatic put(input logic [4:0] v);
		@(posedge clk);
		#2 {gateOk, logicOk, oc, tw, te} = v;
	endtask
	// two sync stages plus the output register, one edge spare
	task automatic settle();
		repeat (4) @(posedge clk);
		#5;
	endtask
	task automatic results();
		if (failCount == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic tPowerUp();
		settle();
		check(st(), 10'h03e);
		host.setReset(1'b1);
		settle();
		check(st(), 10'h000);
		put(5'h18);
		settle();
		check(st(), 10'h3c2);
	endtask
	task automatic tSupply();
		for (int i = 0; i < 2; i++) begin
			put(i ? 5'h10 : 5'h08);
			settle();
			check(st(), 10'h000);
			put(5'h18);
			settle();
			check(st(), 10'h3c2);
		end
	endtask
	task automatic tThermal();
		put(5'h1a);
		settle();
		check(st(), 10'h3c3);
		put(5'h1b);
		settle();
		check(st(), 10'h001);
		put(5'h18);
		settle();
		check(st(), 10'h000);
		host.setReset(1'b0);
		settle();
		check(st(), 10'h03e);
		host.setReset(1'b1);
		settle();
		check(st(), 10'h3c2);
	endtask
	task automatic tOc();
		put(5'h1c);
		put(5'h18);
		settle();
		check(st(), 10'h000);
		// long wait before restart is the controller's duty
		repeat (20) @(posedge clk);
		#2 modeSel = `PWRFLT_MODE_SE;
		host.setReset(1'b0);
		settle();
		check(st(), 10'h002);
		host.setReset(1'b1);
		settle();
		check(st(), 10'h3c2);
	endtask
	task automatic tFreeze();
		put(5'h1a);
		clkEn = 1'b0;
		#3 check(st(), 10'h3c2);
		settle();
		check(st(), 10'h3c2);
		@(posedge clk);
		#2 clkEn = 1'b1;
		// first stage was frozen too, so the warning needs all three enabled edges
		repeat (2) @(posedge clk);
		#5 check(st(), 10'h3c2);
		@(posedge clk);
		#5 check(st(), 10'h3c3);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		sysRst = 1'b1;
		clkEn = 1'b1;
		modeSel = 2'h0;
		{gateOk, logicOk, oc, tw, te} = 5'h00;
		repeat (4) @(posedge clk);
		#2 sysRst = 1'b0;
		tPowerUp();
		tSupply();
		tThermal();
		tOc();
		tFreeze();
		results();
	end
	// whole run needs well under 300 cycles
	initial begin
		repeat (3000) @(posedge clk);
		failCount++;
		results();
	end
endmodule
